//--- src/cbs_cfg.svh
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (subaddresses)
// ----------------------------------------------------------------------------
`define CBS_ADDR_SYSCTL2 8'h05
`define CBS_ADDR_STSP 8'h1A
`define CBS_ADDR_TRIM 8'h1B
`define CBS_ADDR_BANKCTL 8'h50
`define CBS_BANKA_LO 8'h29
`define CBS_BANKA_HI 8'h36
`define CBS_BANKB_LO 8'h3A
`define CBS_BANKB_HI 8'h3F
`define CBS_BANKC_LO 8'h58
`define CBS_BANKC_HI 8'h5F

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CBS_BANKCTL_MSB 2
`define CBS_BANKCTL_LSB 0
`define CBS_SYSCTL2_RST 8'h40
`define CBS_STSP_RST 8'h0F
`define CBS_TRIM_RST 8'h82
`define CBS_MAP_RST 8'h00
`define CBS_COEF_W 26
`define CBS_BANK_ROWS 28
`define CBS_UNITY_323 26'h080_0000
`define CBS_UNITY_917 26'h002_0000

// ----------------------------------------------------------------------------
// Sample-rate codes reported by the rate detector
// ----------------------------------------------------------------------------
`define CBS_RATE_32K 3'h1
`define CBS_RATE_44K 3'h2
`define CBS_RATE_48K 3'h3

`endif

//--- src/cbs_pkg.sv
package cbs_pkg;

    // Bank-switching state, one-hot.
    typedef enum logic [4:0] {
        CBS_ST_DISABLED = 5'b0_0001,
        CBS_ST_LOAD1 = 5'b0_0010,
        CBS_ST_LOAD2 = 5'b0_0100,
        CBS_ST_LOAD3 = 5'b0_1000,
        CBS_ST_AUTO = 5'b1_0000
    } cbs_bank_state_type;

    // Bank-control field codes.
    typedef enum logic [2:0] {
        CBS_CODE_OFF = 3'h0,
        CBS_CODE_LOAD1 = 3'h1,
        CBS_CODE_LOAD2 = 3'h2,
        CBS_CODE_LOAD3 = 3'h3,
        CBS_CODE_AUTO = 3'h4
    } cbs_bank_code_type;

endpackage : cbs_pkg

//--- src/cbs_rate_sync.sv
`timescale 1ns/1ps
`include "cbs_cfg.svh"

// Three-stage synchroniser for the detected rate code; a change is taken once
// the second and third stages agree.
module cbs_rate_sync #(
    parameter int WIDTH = 3
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out,
    output logic change_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;
    logic change_q;

    // ------------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------------
    // Only s2 reads s1, so metastability stays inside the first stage.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a new value only when two stages agree, filtering mid-update codes.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            stable_q <= '0;
            change_q <= 1'b0;
        end else begin
            change_q <= (s2_q == s3_q) && (s3_q != stable_q);
            if (s2_q == s3_q) begin
                stable_q <= s3_q;
            end
        end
    end

    assign stable_out = stable_q;
    assign change_out = change_q;

endmodule : cbs_rate_sync

//--- src/cbs_bank_ctrl.sv
`timescale 1ns/1ps
`include "cbs_cfg.svh"

module cbs_bank_ctrl
    import cbs_pkg::*;
#(
    parameter int NUM_BANKS = 3,
    parameter int SLOTS = 32
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [4:0] wr_word_in,
    input wire logic [31:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic [4:0] rd_word_in,
    input wire logic [2:0] rate_code_in,
    output logic [31:0] rd_data_out,
    output logic coef_wr_out,
    output logic [7:0] coef_addr_out,
    output logic [4:0] coef_word_out,
    output logic [25:0] coef_data_out,
    output logic [2:0] active_bank_out,
    output logic [2:0] bank_code_out,
    output logic shutdown_out,
    output logic [7:0] ramp_period_out
);
    import cbs_pkg::*;

    // Storage indexing assumes three banks of exactly 32 word slots per subaddress.
    if (NUM_BANKS != 3 || SLOTS != 32) begin : g_param_check
        $error("cbs_bank_ctrl: unsupported NUM_BANKS or SLOTS");
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Bankable locations are three disjoint subaddress windows.
    function automatic logic is_bankable(input logic [7:0] a);
        is_bankable = (a >= `CBS_BANKA_LO && a <= `CBS_BANKA_HI) ||
                      (a >= `CBS_BANKB_LO && a <= `CBS_BANKB_HI) ||
                      (a >= `CBS_BANKC_LO && a <= `CBS_BANKC_HI);
    endfunction : is_bankable

    // Packs subaddress and word into a dense storage slot index.
    function automatic logic [9:0] slot_of(input logic [7:0] a, input logic [4:0] w);
        logic [7:0] base;
        base = 8'h00;
        if (a <= `CBS_BANKA_HI) begin
            base = a - `CBS_BANKA_LO;
        end else if (a <= `CBS_BANKB_HI) begin
            base = a - `CBS_BANKB_LO + 8'd14;
        end else begin
            base = a - `CBS_BANKC_LO + 8'd20;
        end
        slot_of = {base[4:0], w};
    endfunction : slot_of

    // Turns a dense storage row back into the subaddress that it mirrors.
    function automatic logic [7:0] addr_of_row(input logic [4:0] r);
        if (r < 5'd14) begin
            addr_of_row = `CBS_BANKA_LO + {3'b000, r};
        end else if (r < 5'd20) begin
            addr_of_row = `CBS_BANKB_LO + {3'b000, r} - 8'd14;
        end else begin
            addr_of_row = `CBS_BANKC_LO + {3'b000, r} - 8'd20;
        end
    endfunction : addr_of_row

    // Maps a rate code to a bank index via the two mapping registers.
    function automatic logic [1:0] bank_for_rate(input logic [2:0] r,
                                                 input logic [7:0] m1,
                                                 input logic [7:0] m2);
        if (m1[r]) begin
            bank_for_rate = 2'd0;
        end else if (m2[r]) begin
            bank_for_rate = 2'd1;
        end else begin
            bank_for_rate = 2'd2;
        end
    endfunction : bank_for_rate

    // ------------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------------
    cbs_bank_state_type state_q;
    logic [2:0] field_q;
    logic [7:0] sysctl_q;
    logic [7:0] stsp_q;
    logic [7:0] trim_q;
    logic [7:0] map1_q;
    logic [7:0] map2_q;
    logic [25:0] bank_mem [0:NUM_BANKS-1][0:1023];
    logic [1:0] cur_bank_q;
    logic [2:0] active_bank_q;
    logic [2:0] rate_stable;
    logic rate_change;
    logic swap_busy_q;
    logic [9:0] swap_idx_q;
    logic [1:0] swap_bank_q;
    logic [31:0] rd_data_q;
    logic coef_wr_q;
    logic [7:0] coef_addr_q;
    logic [4:0] coef_word_q;
    logic [25:0] coef_data_q;

    cbs_rate_sync #(
        .WIDTH(3)
    ) u_rate_sync (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .async_in(rate_code_in),
        .stable_out(rate_stable),
        .change_out(rate_change)
    );

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    // Rate maps sit in the upper bytes of 0x50; default selects 32k and 44.1/48k.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            field_q <= 3'h0;
            sysctl_q <= `CBS_SYSCTL2_RST;
            stsp_q <= `CBS_STSP_RST;
            trim_q <= `CBS_TRIM_RST;
            map1_q <= 8'h02;
            map2_q <= 8'h0C;
        end else if (wr_en_in && wr_word_in == 5'd0) begin
            if (wr_addr_in == `CBS_ADDR_SYSCTL2) begin
                sysctl_q <= wr_data_in[7:0];
            end else if (wr_addr_in == `CBS_ADDR_STSP) begin
                stsp_q <= wr_data_in[7:0];
            end else if (wr_addr_in == `CBS_ADDR_TRIM) begin
                trim_q <= wr_data_in[7:0];
            end else if (wr_addr_in == `CBS_ADDR_BANKCTL) begin
                map1_q <= wr_data_in[31:24];
                map2_q <= wr_data_in[23:16];
                if (wr_data_in[2:0] <= CBS_CODE_AUTO) begin
                    field_q <= wr_data_in[2:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Bank-switching state machine
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_q <= CBS_ST_DISABLED;
        end else if (wr_en_in && wr_word_in == 5'd0 && wr_addr_in == `CBS_ADDR_BANKCTL) begin
            case (wr_data_in[2:0])
                CBS_CODE_OFF: begin
                    state_q <= CBS_ST_DISABLED;
                end
                CBS_CODE_LOAD1: begin
                    state_q <= CBS_ST_LOAD1;
                end
                CBS_CODE_LOAD2: begin
                    state_q <= CBS_ST_LOAD2;
                end
                CBS_CODE_LOAD3: begin
                    state_q <= CBS_ST_LOAD3;
                end
                CBS_CODE_AUTO: begin
                    state_q <= CBS_ST_AUTO;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Stored banks
    // ------------------------------------------------------------------------
    // Load states route bankable writes into storage instead of the live path.
    always_ff @(posedge core_clk_in) begin
        if (wr_en_in && is_bankable(wr_addr_in)) begin
            if (state_q == CBS_ST_LOAD1) begin
                bank_mem[0][slot_of(wr_addr_in, wr_word_in)] <= wr_data_in[25:0];
            end else if (state_q == CBS_ST_LOAD2) begin
                bank_mem[1][slot_of(wr_addr_in, wr_word_in)] <= wr_data_in[25:0];
            end else if (state_q == CBS_ST_LOAD3) begin
                bank_mem[2][slot_of(wr_addr_in, wr_word_in)] <= wr_data_in[25:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Automatic swap engine
    // ------------------------------------------------------------------------
    // The swap streams a whole bank into the live coefficients; a rate change
    // mid-swap restarts with the new bank so the last rate always wins.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            swap_busy_q <= 1'b0;
            swap_idx_q <= 10'h000;
            swap_bank_q <= 2'd0;
            cur_bank_q <= 2'd1;
            active_bank_q <= 3'd2;
        end else if (state_q == CBS_ST_AUTO && rate_change) begin
            swap_busy_q <= 1'b1;
            swap_idx_q <= 10'h000;
            swap_bank_q <= bank_for_rate(rate_stable, map1_q, map2_q);
            cur_bank_q <= bank_for_rate(rate_stable, map1_q, map2_q);
            active_bank_q <= 3'(bank_for_rate(rate_stable, map1_q, map2_q)) + 3'd1;
        end else if (state_q != CBS_ST_AUTO) begin
            swap_busy_q <= 1'b0;
        end else if (swap_busy_q) begin
            swap_idx_q <= swap_idx_q + 10'd1;
            // All three bankable windows are streamed, so no window keeps an old rate's set.
            if (swap_idx_q == 10'(SLOTS * `CBS_BANK_ROWS - 1)) begin
                swap_busy_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Live coefficient write port
    // ------------------------------------------------------------------------
    // Host writes reach the live port only in the disabled state; a swap drives it only in automatic mode.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            coef_wr_q <= 1'b0;
            coef_addr_q <= 8'h00;
            coef_word_q <= 5'd0;
            coef_data_q <= 26'h000_0000;
        end else if (wr_en_in && is_bankable(wr_addr_in) && state_q == CBS_ST_DISABLED) begin
            coef_wr_q <= 1'b1;
            coef_addr_q <= wr_addr_in;
            coef_word_q <= wr_word_in;
            coef_data_q <= wr_data_in[25:0];
        end else if (swap_busy_q && state_q == CBS_ST_AUTO) begin
            coef_wr_q <= 1'b1;
            coef_addr_q <= addr_of_row(swap_idx_q[9:5]);
            coef_word_q <= swap_idx_q[4:0];
            coef_data_q <= bank_mem[swap_bank_q][swap_idx_q];
        end else begin
            coef_wr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Narrow registers are zero-extended to the full word.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rd_data_q <= 32'h0000_0000;
        end else if (rd_en_in) begin
            if (rd_addr_in == `CBS_ADDR_SYSCTL2) begin
                rd_data_q <= {24'h00_0000, sysctl_q};
            end else if (rd_addr_in == `CBS_ADDR_STSP) begin
                rd_data_q <= {24'h00_0000, stsp_q};
            end else if (rd_addr_in == `CBS_ADDR_TRIM) begin
                rd_data_q <= {24'h00_0000, trim_q};
            end else if (rd_addr_in == `CBS_ADDR_BANKCTL) begin
                rd_data_q <= {map1_q, map2_q, 13'h0000, field_q};
            end else if (is_bankable(rd_addr_in) && rd_word_in < 5'd5) begin
                rd_data_q <= {6'h00, bank_mem[cur_bank_q][slot_of(rd_addr_in, rd_word_in)]};
            end else begin
                rd_data_q <= 32'h0000_0000;
            end
        end
    end

    assign rd_data_out = rd_data_q;
    assign coef_wr_out = coef_wr_q;
    assign coef_addr_out = coef_addr_q;
    assign coef_word_out = coef_word_q;
    assign coef_data_out = coef_data_q;
    assign active_bank_out = active_bank_q;
    assign bank_code_out = field_q;
    assign shutdown_out = sysctl_q[6];
    assign ramp_period_out = stsp_q;

endmodule : cbs_bank_ctrl

//--- verification/cbs_bank_ctrl_properties.sv
`timescale 1ns/1ps
`include "cbs_cfg.svh"

// ----------------------------------------------------------------------------
// Port-level checker for the bank controller.
// ----------------------------------------------------------------------------
module cbs_bank_ctrl_properties #(
    parameter int NUM_BANKS = 3,
    parameter int SLOTS = 32
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [4:0] wr_word_in,
    input wire logic [31:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic [4:0] rd_word_in,
    input wire logic [2:0] rate_code_in,
    input wire logic [31:0] rd_data_out,
    input wire logic coef_wr_out,
    input wire logic [7:0] coef_addr_out,
    input wire logic [4:0] coef_word_out,
    input wire logic [25:0] coef_data_out,
    input wire logic [2:0] active_bank_out,
    input wire logic [2:0] bank_code_out,
    input wire logic shutdown_out,
    input wire logic [7:0] ramp_period_out
);
    logic wr_one;
    logic wr_bank;
    logic wr_ctl;
    logic [31:0] wdat_q;
    logic [7:0] wadr_q;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    // Decode the write target once so every property reads the same way.
    assign wr_bank = wr_en_in && (wr_addr_in inside {[`CBS_BANKA_LO:`CBS_BANKA_HI],
        [`CBS_BANKB_LO:`CBS_BANKB_HI], [`CBS_BANKC_LO:`CBS_BANKC_HI]});
    // Single-word registers only take word 0, so the control decodes insist on it.
    assign wr_one = wr_en_in && (wr_word_in == 5'd0);
    assign wr_ctl = wr_one && (wr_addr_in == `CBS_ADDR_BANKCTL);

    // Delayed copies avoid slicing a sampled-value result.
    always_ff @(posedge core_clk_in) begin
        wdat_q <= wr_data_in;
        wadr_q <= wr_addr_in;
    end

    AST_CODE_RST: assert property (disable iff (1'b0) !resetn_in |=> bank_code_out == 3'h0)
        else $error("bank code not cleared by reset");
    AST_SD_RST: assert property (disable iff (1'b0) !resetn_in |=> shutdown_out)
        else $error("device not in shutdown after reset");
    AST_CODE_WR: assert property (wr_ctl && wr_data_in[2:0] <= 3'h4 |=> bank_code_out == wdat_q[2:0])
        else $error("bank code write not taken");
    AST_CODE_RSV: assert property (wr_ctl && wr_data_in[2:0] > 3'h4 |=> $stable(bank_code_out))
        else $error("reserved bank code changed state");
    AST_LIVE: assert property (bank_code_out == 3'h0 && wr_bank |=> coef_wr_out
        && coef_data_out == wdat_q[25:0] && coef_addr_out == wadr_q)
        else $error("disabled mode write not applied live");
    AST_LOAD_HOLD: assert property (bank_code_out inside {[3'h1:3'h3]} && wr_bank |=> !coef_wr_out)
        else $error("load state write reached live set");
    AST_NO_SWAP: assert property (bank_code_out <= 3'h3 |=> $stable(active_bank_out))
        else $error("active bank moved outside automatic mode");
    AST_RAMP: assert property (wr_one && wr_addr_in == `CBS_ADDR_STSP |=> ramp_period_out == wdat_q[7:0])
        else $error("ramp period does not follow its register");
    AST_SD_WR: assert property (wr_one && wr_addr_in == `CBS_ADDR_SYSCTL2 |=> shutdown_out == wdat_q[6])
        else $error("shutdown level does not follow bit 6");
    AST_RD_ZERO: assert property (rd_en_in && rd_addr_in < 8'h20 |=> rd_data_out[31:8] == 24'h00_0000)
        else $error("unused read bits not zero");
    AST_SWAP_ADDR: assert property (coef_wr_out |-> coef_addr_out inside {
        [`CBS_BANKA_LO:`CBS_BANKA_HI], [`CBS_BANKB_LO:`CBS_BANKB_HI],
        [`CBS_BANKC_LO:`CBS_BANKC_HI]})
        else $error("live coefficient write outside bankable range");

    cover property (bank_code_out == 3'h4 && coef_wr_out);
    cover property (wr_ctl && wr_data_in[2:0] > 3'h4);
    cover property ($fell(shutdown_out));
    cover property (bank_code_out == 3'h4 && $fell(coef_wr_out));
endmodule : cbs_bank_ctrl_properties

bind cbs_bank_ctrl cbs_bank_ctrl_properties #(.NUM_BANKS(NUM_BANKS), .SLOTS(SLOTS)) i_props (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .wr_en_in(wr_en_in),
    .wr_addr_in(wr_addr_in), .wr_word_in(wr_word_in), .wr_data_in(wr_data_in),
    .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_word_in(rd_word_in),
    .rate_code_in(rate_code_in), .rd_data_out(rd_data_out), .coef_wr_out(coef_wr_out),
    .coef_addr_out(coef_addr_out), .coef_word_out(coef_word_out),
    .coef_data_out(coef_data_out), .active_bank_out(active_bank_out),
    .bank_code_out(bank_code_out), .shutdown_out(shutdown_out),
    .ramp_period_out(ramp_period_out));

//--- verification/cbs_host_model.sv
`timescale 1ns/1ps

// Host controller: one 32-bit word per strobe, driven on the falling edge.
module cbs_host_model (
    input wire logic core_clk_in,
    input wire logic [31:0] rd_data_in,
    output logic wr_en_out = 1'b0,
    output logic [7:0] wr_addr_out = 8'h00,
    output logic [4:0] wr_word_out = 5'h00,
    output logic [31:0] wr_data_out = 32'h0000_0000,
    output logic rd_en_out = 1'b0,
    output logic [7:0] rd_addr_out = 8'h00,
    output logic [4:0] rd_word_out = 5'h00
);
    // Released address and data fields are inverted so stale values cannot pass for good ones.
    task automatic write_reg(input logic [7:0] a, input logic [4:0] w, input logic [31:0] d);
        @(negedge core_clk_in);
        wr_en_out = 1'b1;
        wr_addr_out = a;
        wr_word_out = w;
        wr_data_out = d;
        @(negedge core_clk_in);
        wr_en_out = 1'b0;
        wr_addr_out = ~a;
        wr_data_out = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(negedge core_clk_in);
        rd_en_out = 1'b1;
        rd_addr_out = a;
        rd_word_out = 5'h00;
        @(negedge core_clk_in);
        rd_en_out = 1'b0;
        rd_addr_out = ~a;
        d = rd_data_in;
    endtask : read_reg
endmodule : cbs_host_model

//--- verification/tb_cbs_bank_ctrl.sv
`timescale 1ns/1ps

module tb_cbs_bank_ctrl;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] rate_code_in = 3'h0;
    logic wr_en, rd_en, coef_wr_out, shutdown_out;
    logic [7:0] wr_addr, rd_addr, coef_addr_out, ramp_period_out;
    logic [4:0] wr_word, rd_word, coef_word_out;
    logic [31:0] wr_data, rd_data_out, rv;
    logic [25:0] coef_data_out;
    logic [2:0] active_bank_out, bank_code_out;
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    always #4 core_clk_in = ~core_clk_in;

    cbs_bank_ctrl i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .wr_en_in(wr_en),
        .wr_addr_in(wr_addr), .wr_word_in(wr_word), .wr_data_in(wr_data), .rd_en_in(rd_en),
        .rd_addr_in(rd_addr), .rd_word_in(rd_word), .rate_code_in(rate_code_in),
        .rd_data_out(rd_data_out), .coef_wr_out(coef_wr_out), .coef_addr_out(coef_addr_out),
        .coef_word_out(coef_word_out), .coef_data_out(coef_data_out),
        .active_bank_out(active_bank_out), .bank_code_out(bank_code_out),
        .shutdown_out(shutdown_out), .ramp_period_out(ramp_period_out));

    cbs_host_model i_host (.core_clk_in(core_clk_in), .rd_data_in(rd_data_out),
        .wr_en_out(wr_en), .wr_addr_out(wr_addr), .wr_word_out(wr_word), .wr_data_out(wr_data),
        .rd_en_out(rd_en), .rd_addr_out(rd_addr), .rd_word_out(rd_word));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    // A hung handshake must still end in the verdict.
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test;
        end
    end

    task automatic t_reset;
        check(bank_code_out, 3'h0);
        check(shutdown_out, 1'b1);
        check(ramp_period_out, 8'h0F);
        check(active_bank_out, 3'h2);
        i_host.read_reg(8'h05, rv);
        check(rv, 32'h0000_0040);
        i_host.read_reg(8'h0B, rv);
        check(rv, 32'h0000_0000);
        i_host.write_reg(8'h1B, 5'h00, 32'h0000_0000);
        i_host.read_reg(8'h1B, rv);
        check(rv, 32'h0000_0000);
        $display("t_reset done");
    endtask : t_reset

    // Both ends of every bankable range, plus the outside neighbours 0x28, 0x37, 0x40 and 0x57.
    task automatic t_live;
        logic [7:0] adr [10] = '{8'h28, 8'h29, 8'h36, 8'h37, 8'h3A, 8'h3F, 8'h40, 8'h57, 8'h58,
            8'h5F};
        logic [31:0] cf [3] = '{32'h0080_0000, 32'h0002_0000, 32'h0380_0000};
        logic [9:0] bk = 10'h336;
        for (int i = 0; i < 10; i++) begin
            i_host.write_reg(adr[i], 5'(i % 5), cf[i % 3]);
            check(coef_wr_out, bk[i]);
            if (bk[i]) check(coef_data_out, cf[i % 3][25:0]);
            if (bk[i]) check(coef_addr_out, adr[i]);
            if (bk[i]) check(coef_word_out, 5'(i % 5));
        end
        rate_code_in = 3'h1;
        repeat (30) @(negedge core_clk_in);
        check(active_bank_out, 3'h2);
        $display("t_live done");
    endtask : t_live

    task automatic t_load;
        for (int c = 1; c < 8; c++) begin
            // Code 100 would enter automatic mode, which has a scenario of its own.
            if (c == 4) continue;
            i_host.write_reg(8'h50, 5'h00, 32'h020C_0000 | c);
            check(bank_code_out, (c < 4) ? c : 3);
            i_host.write_reg(8'h29, 5'h00, 32'h0080_0000 + c);
            check(coef_wr_out, 1'b0);
            rate_code_in = 3'(c + 1);
            repeat (30) @(negedge core_clk_in);
            check(active_bank_out, 3'h2);
        end
        i_host.read_reg(8'h50, rv);
        check(rv[2:0], 3'h3);
        $display("t_load done");
    endtask : t_load

    // Each new rate must swap in its mapped bank with coefficient traffic.
    task automatic t_auto;
        logic [2:0] rt [4] = '{3'h1, 3'h3, 3'h6, 3'h2};
        logic [2:0] bn [4] = '{3'h1, 3'h2, 3'h3, 3'h2};
        logic [25:0] ex [4] = '{26'h080_0001, 26'h080_0002, 26'h080_0007, 26'h080_0002};
        logic [25:0] seen;
        int p;
        i_host.write_reg(8'h50, 5'h00, 32'h020C_0004);
        check(bank_code_out, 3'h4);
        for (int i = 0; i < 4; i++) begin
            p = 0;
            seen = 26'h3FF_FFFF;
            rate_code_in = rt[i];
            repeat (1500) begin
                @(negedge core_clk_in);
                if (coef_wr_out === 1'b1) p++;
                // Subaddress 0x29 word 0 is the slot that t_load filled in each bank.
                if (coef_wr_out === 1'b1 && {coef_addr_out, coef_word_out} == 13'h0520) begin
                    seen = coef_data_out;
                end
            end
            check(active_bank_out, bn[i]);
            check(p, 28 * 32);
            check(seen, ex[i]);
            check(coef_wr_out, 1'b0);
        end
        $display("t_auto done");
    endtask : t_auto

    task automatic t_shutdown;
        i_host.write_reg(8'h1A, 5'h00, 32'h0000_0020);
        check(ramp_period_out, 8'h20);
        i_host.write_reg(8'h05, 5'h00, 32'h0000_0000);
        check(shutdown_out, 1'b0);
        i_host.write_reg(8'h05, 5'h00, 32'h0000_0040);
        check(shutdown_out, 1'b1);
        $display("t_shutdown done");
    endtask : t_shutdown

    // A second reset in mid-run must bring the bank code, shutdown, active bank, ramp period and live write strobe back to their defaults.
    task automatic t_rerun;
        resetn_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        resetn_in = 1'b1;
        check(bank_code_out, 3'h0);
        check(shutdown_out, 1'b1);
        check(active_bank_out, 3'h2);
        check(ramp_period_out, 8'h0F);
        check(coef_wr_out, 1'b0);
        $display("t_rerun done");
    endtask : t_rerun

    initial begin
        repeat (10) @(negedge core_clk_in);
        resetn_in = 1'b1;
        t_reset();
        t_live();
        t_load();
        t_auto();
        t_shutdown();
        t_rerun();
        finish_test();
    end
endmodule : tb_cbs_bank_ctrl
